/* design/dual_port_pkg.sv */
// constants for the dual bidirectional port block
package dual_port_pkg;
    // register indices (printed offsets, not multiples of four)
    localparam logic [7:0] fourth_port_data_idx = 8'h08;
    localparam logic [7:0] third_port_direction_idx = 8'h87;
    localparam logic [7:0] fourth_port_direction_idx = 8'h88;
    localparam logic [7:0] fifth_port_direction_status_idx = 8'h89;
    localparam logic [7:0] third_port_data_idx = 8'h07;
    localparam logic [7:0] override_out_idx = 8'h90;
    localparam logic [7:0] override_in_idx = 8'h91;
    localparam logic [7:0] irq_status_idx = 8'h92;
    localparam logic [7:0] irq_mask_idx = 8'h93;
    localparam int addr_w = 12;
    // reset values
    localparam logic [7:0] direction_reset = 8'hFF;
    localparam logic [7:0] fifth_reset = 8'h07;
    // field positions of the port-E direction and status register
    localparam int input_buffer_full_pos = 7;
    localparam int output_buffer_full_pos = 6;
    localparam int input_overflow_pos = 5;
    localparam int parallel_slave_select_bit_pos = 4;
    localparam int fifth_dir_msb = 2;
    localparam logic [7:0] fifth_write_mask = 8'h17;
    // interrupt status bits
    localparam int irq_third_change_pos = 0;
    localparam int irq_fourth_change_pos = 1;
    localparam int irq_w = 2;
    // axi response codes
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

/* design/pin_bank_if.sv */
// interface carrying one 8-bit pin bank between modules
`timescale 1ns/1ps
interface pin_bank_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pins_sync;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic changed;
    modport ctrl (output latch, output dir, input pins_sync, input changed);
    modport bank (input latch, input dir, output pins_sync, output pin_out, output pin_oe,
        output changed);
endinterface

/* design/pin_bank.sv */
// one 8-bit bidirectional pin bank with input synchroniser
`timescale 1ns/1ps
module pin_bank (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic [7:0] pin_in, // pad levels
    pin_bank_if.bank b // bank control and status
);
    logic [7:0] meta_reg;
    logic [7:0] sync_reg;
    logic [7:0] prev_reg;
    // two-stage synchroniser on the pad levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 8'h00;
            sync_reg <= 8'h00;
            prev_reg <= 8'h00;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end
    assign b.pins_sync = sync_reg;
    assign b.changed = |(sync_reg ^ prev_reg);
    // driver enable is the inverse of the direction bit
    assign b.pin_oe = ~b.dir;
    assign b.pin_out = b.latch;
endmodule // pin_bank

/* design/dual_bidirectional_port.sv */
// two 8-bit bidirectional ports with axi4-lite register access
`timescale 1ns/1ps
module dual_bidirectional_port
    import dual_port_pkg::*;
(
    input wire logic aclk, // clock, 50 MHz
    input wire logic aresetn, // synchronous reset, low active
    input wire logic [dual_port_pkg::addr_w-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [dual_port_pkg::addr_w-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [7:0] third_port_in, // third port pad levels
    output logic [7:0] third_port_out, // third port pad drive value
    output logic [7:0] third_port_oe, // third port pad drive enable
    input wire logic [7:0] fourth_port_in, // fourth port pad levels
    output logic [7:0] fourth_port_out, // fourth port pad drive value
    output logic [7:0] fourth_port_oe, // fourth port pad drive enable
    input wire logic [7:0] slave_data_in, // parallel slave byte to drive out
    output logic [7:0] slave_data_out, // parallel slave byte seen on pins
    output logic parallel_slave_select, // slave mode active
    input wire logic input_buffer_full_set, // slave hardware: input byte arrived
    input wire logic output_buffer_full_set, // slave hardware: output byte loaded
    input wire logic output_buffer_full_clr, // slave hardware: output byte taken
    input wire logic slave_drive, // slave hardware: drive pins this cycle
    output logic irq // interrupt, high level
);
    import dual_port_pkg::*;

    typedef enum logic [1:0] {w_idle, w_resp} wr_state_e;
    typedef enum logic [1:0] {r_idle, r_resp} rd_state_e;

    pin_bank_if third_if();
    pin_bank_if fourth_if();

    logic [7:0] third_latch_reg;
    logic [7:0] fourth_latch_reg;
    logic [7:0] third_dir_reg;
    logic [7:0] fourth_dir_reg;
    logic [7:0] fifth_reg;
    logic [7:0] ovr_out_reg;
    logic [7:0] ovr_in_reg;
    logic [irq_w-1:0] irq_status_reg;
    logic [irq_w-1:0] irq_mask_reg;
    logic [7:0] third_dir_eff;
    logic [7:0] fourth_dir_eff;
    logic ibf_set_sync1_reg, ibf_set_reg, obf_set_sync1_reg, obf_set_reg;
    logic obf_clr_sync1_reg, obf_clr_reg, drv_sync1_reg, drv_reg;

    wr_state_e wr_state_reg;
    rd_state_e rd_state_reg;
    logic aw_have_reg, w_have_reg;
    logic [addr_w-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic w_strb_reg;
    logic [7:0] w_idx;
    logic [7:0] r_idx;
    logic w_fire;
    logic w_hit;
    logic [31:0] r_data;
    logic r_hit;

    // the two pin banks
    pin_bank u_third (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(third_port_in),
        .b(third_if.bank)
    );
    pin_bank u_fourth (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(fourth_port_in),
        .b(fourth_if.bank)
    );

    // peripheral override: forced-out wins over forced-in, stored bits untouched
    assign third_dir_eff = (third_dir_reg | ovr_in_reg) & ~ovr_out_reg;
    assign third_if.dir = third_dir_eff;
    assign third_if.latch = third_latch_reg;
    // slave mode: pins follow the slave hardware, not the direction register
    assign fourth_dir_eff = fifth_reg[parallel_slave_select_bit_pos] ?
        {8{~drv_reg}} : fourth_dir_reg;
    assign fourth_if.dir = fourth_dir_eff;
    assign fourth_if.latch = fifth_reg[parallel_slave_select_bit_pos] ?
        slave_data_in : fourth_latch_reg;

    // pad outputs and status outputs, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            third_port_out <= 8'h00;
            third_port_oe <= 8'h00;
            fourth_port_out <= 8'h00;
            fourth_port_oe <= 8'h00;
            slave_data_out <= 8'h00;
            parallel_slave_select <= 1'b0;
            irq <= 1'b0;
        end else begin
            third_port_out <= third_if.pin_out;
            third_port_oe <= third_if.pin_oe;
            fourth_port_out <= fourth_if.pin_out;
            fourth_port_oe <= fourth_if.pin_oe;
            slave_data_out <= fourth_if.pins_sync;
            parallel_slave_select <= fifth_reg[parallel_slave_select_bit_pos];
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // synchronisers for slave-hardware strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ibf_set_sync1_reg <= 1'b0;
            ibf_set_reg <= 1'b0;
            obf_set_sync1_reg <= 1'b0;
            obf_set_reg <= 1'b0;
            obf_clr_sync1_reg <= 1'b0;
            obf_clr_reg <= 1'b0;
            drv_sync1_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else begin
            ibf_set_sync1_reg <= input_buffer_full_set;
            ibf_set_reg <= ibf_set_sync1_reg;
            obf_set_sync1_reg <= output_buffer_full_set;
            obf_set_reg <= obf_set_sync1_reg;
            obf_clr_sync1_reg <= output_buffer_full_clr;
            obf_clr_reg <= obf_clr_sync1_reg;
            drv_sync1_reg <= slave_drive;
            drv_reg <= drv_sync1_reg;
        end
    end

    // write channel capture, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 1'b0;
            wr_state_reg <= w_idle;
        end else begin
            case (wr_state_reg)
                w_idle: begin
                    if (s_axi_awvalid && !aw_have_reg) begin
                        aw_have_reg <= 1'b1;
                        aw_addr_reg <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && !w_have_reg) begin
                        w_have_reg <= 1'b1;
                        w_data_reg <= s_axi_wdata;
                        w_strb_reg <= s_axi_wstrb[0];
                    end
                    if (w_fire) begin
                        wr_state_reg <= w_resp;
                    end
                end
                w_resp: begin
                    aw_have_reg <= 1'b0;
                    w_have_reg <= 1'b0;
                    if (s_axi_bready) begin
                        wr_state_reg <= w_idle;
                    end
                end
                default: wr_state_reg <= w_idle;
            endcase
        end
    end
    assign s_axi_awready = (wr_state_reg == w_idle) && !aw_have_reg;
    assign s_axi_wready = (wr_state_reg == w_idle) && !w_have_reg;
    assign s_axi_bvalid = (wr_state_reg == w_resp);
    assign w_fire = (wr_state_reg == w_idle) && aw_have_reg && w_have_reg;
    assign w_idx = aw_addr_reg[9:2];

    // write address decode
    always_comb begin
        w_hit = 1'b1;
        if (aw_addr_reg[1:0] != 2'h0 || aw_addr_reg[addr_w-1:10] != '0) begin
            w_hit = 1'b0;
        end else if (w_idx == third_port_data_idx || w_idx == fourth_port_data_idx) begin
            w_hit = 1'b1;
        end else if (w_idx == third_port_direction_idx || w_idx == fourth_port_direction_idx) begin
            w_hit = 1'b1;
        end else if (w_idx == fifth_port_direction_status_idx || w_idx == override_out_idx) begin
            w_hit = 1'b1;
        end else if (w_idx == override_in_idx || w_idx == irq_status_idx) begin
            w_hit = 1'b1;
        end else if (w_idx == irq_mask_idx) begin
            w_hit = 1'b1;
        end else begin
            w_hit = 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= resp_okay;
        end else if (w_fire) begin
            s_axi_bresp <= w_hit ? resp_okay : resp_slverr;
        end
    end

    // software-written registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            third_latch_reg <= 8'h00;
            fourth_latch_reg <= 8'h00;
            third_dir_reg <= direction_reset;
            fourth_dir_reg <= direction_reset;
            ovr_out_reg <= 8'h00;
            ovr_in_reg <= 8'h00;
            irq_mask_reg <= '0;
        end else if (w_fire && w_strb_reg && w_hit) begin
            if (w_idx == third_port_data_idx) begin
                third_latch_reg <= w_data_reg[7:0];
            end else if (w_idx == fourth_port_data_idx) begin
                fourth_latch_reg <= w_data_reg[7:0];
            end else if (w_idx == third_port_direction_idx) begin
                third_dir_reg <= w_data_reg[7:0];
            end else if (w_idx == fourth_port_direction_idx) begin
                fourth_dir_reg <= w_data_reg[7:0];
            end else if (w_idx == override_out_idx) begin
                ovr_out_reg <= w_data_reg[7:0];
            end else if (w_idx == override_in_idx) begin
                ovr_in_reg <= w_data_reg[7:0];
            end else if (w_idx == irq_mask_idx) begin
                irq_mask_reg <= w_data_reg[irq_w-1:0];
            end
        end
    end

    // port-E register: flags set by slave hardware, set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifth_reg <= fifth_reset;
        end else begin
            if (w_fire && w_strb_reg && w_hit && w_idx == fifth_port_direction_status_idx) begin
                fifth_reg[parallel_slave_select_bit_pos] <=
                    w_data_reg[parallel_slave_select_bit_pos];
                fifth_reg[fifth_dir_msb:0] <= w_data_reg[fifth_dir_msb:0];
                if (!w_data_reg[input_overflow_pos]) begin
                    fifth_reg[input_overflow_pos] <= 1'b0;
                end
            end
            if (ibf_set_reg) begin
                fifth_reg[input_buffer_full_pos] <= 1'b1;
                if (fifth_reg[input_buffer_full_pos]) begin
                    fifth_reg[input_overflow_pos] <= 1'b1;
                end
            end
            if (obf_set_reg) begin
                fifth_reg[output_buffer_full_pos] <= 1'b1;
            end else if (obf_clr_reg) begin
                fifth_reg[output_buffer_full_pos] <= 1'b0;
            end
            if (r_hit && s_axi_arvalid && s_axi_arready && r_idx == fourth_port_data_idx
                    && !ibf_set_reg) begin
                fifth_reg[input_buffer_full_pos] <= 1'b0;
            end
            fifth_reg[3] <= 1'b0; // unimplemented, reads zero
        end
    end

    // interrupt status: pin change events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= '0;
        end else begin
            for (int i = 0; i < irq_w; i++) begin
                if (w_fire && w_strb_reg && w_idx == irq_status_idx && w_data_reg[i]) begin
                    irq_status_reg[i] <= 1'b0;
                end
            end
            if (third_if.changed) begin
                irq_status_reg[irq_third_change_pos] <= 1'b1;
            end
            if (fourth_if.changed) begin
                irq_status_reg[irq_fourth_change_pos] <= 1'b1;
            end
        end
    end

    // read decode; data registers return synchronised pin levels
    assign r_idx = s_axi_araddr[9:2];
    always_comb begin
        r_data = 32'h00000000;
        r_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[addr_w-1:10] == '0);
        if (!r_hit) begin
            r_data = 32'h00000000;
        end else if (r_idx == third_port_data_idx) begin
            r_data[7:0] = third_if.pins_sync;
        end else if (r_idx == fourth_port_data_idx) begin
            r_data[7:0] = fourth_if.pins_sync;
        end else if (r_idx == third_port_direction_idx) begin
            r_data[7:0] = third_dir_reg;
        end else if (r_idx == fourth_port_direction_idx) begin
            r_data[7:0] = fourth_dir_reg;
        end else if (r_idx == fifth_port_direction_status_idx) begin
            r_data[7:0] = fifth_reg & ~8'h08;
        end else if (r_idx == override_out_idx) begin
            r_data[7:0] = ovr_out_reg;
        end else if (r_idx == override_in_idx) begin
            r_data[7:0] = ovr_in_reg;
        end else if (r_idx == irq_status_idx) begin
            r_data[irq_w-1:0] = irq_status_reg;
        end else if (r_idx == irq_mask_idx) begin
            r_data[irq_w-1:0] = irq_mask_reg;
        end else begin
            r_hit = 1'b0;
        end
    end

    // read channel: one cycle to answer, held until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_reg <= r_idle;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= resp_okay;
        end else begin
            case (rd_state_reg)
                r_idle: begin
                    if (s_axi_arvalid) begin
                        s_axi_rdata <= r_data;
                        s_axi_rresp <= r_hit ? resp_okay : resp_slverr;
                        rd_state_reg <= r_resp;
                    end
                end
                r_resp: begin
                    if (s_axi_rready) begin
                        rd_state_reg <= r_idle;
                    end
                end
                default: rd_state_reg <= r_idle;
            endcase
        end
    end
    assign s_axi_arready = (rd_state_reg == r_idle);
    assign s_axi_rvalid = (rd_state_reg == r_resp);
endmodule // dual_bidirectional_port

/* tb/port_checker.sv */
// concurrent checks on the register bus handshake and slave-mode pins
`timescale 1ns/1ps
module port_checker
    import dual_port_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // synchronous reset, low active
    input wire logic s_axi_awvalid, // write address valid
    input wire logic s_axi_awready, // write address ready
    input wire logic s_axi_wvalid, // write data valid
    input wire logic s_axi_wready, // write data ready
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // read response
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [7:0] fourth_port_oe, // fourth port drive enable
    input wire logic parallel_slave_select // slave mode active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address and data taken together, then one fire cycle before the answer
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_resp_after;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_write_answer: assert property (s_wr_taken |=> s_resp_after)
        else $error("write response not two cycles after accept");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after accept");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before ready");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during read data");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_slave_all_pins: assert property (parallel_slave_select && $past(parallel_slave_select) && $past(parallel_slave_select, 2) && fourth_port_oe != 8'h00 |-> fourth_port_oe == 8'hFF)
        else $error("slave mode drove a partial byte");
endmodule // port_checker

/* tb/tb_top.sv */
// self-checking bench for the dual bidirectional port block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import dual_port_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [addr_w-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] third_port_in = '0, fourth_port_in = '0, slave_data_in = '0;
    logic [7:0] third_port_out, third_port_oe, fourth_port_out, fourth_port_oe, slave_data_out;
    logic [2:0] hs = '0;
    logic slave_drive = 1'h0;
    logic parallel_slave_select, irq;
    int bad_count = 0;
    int n_tests = 0;
    // free-running 50 MHz clock
    always #10 aclk = ~aclk;
    dual_bidirectional_port dual_bidirectional_port_inst (.*, .s_axi_wstrb(4'hF),
        .input_buffer_full_set(hs[0]),
        .output_buffer_full_set(hs[1]),
        .output_buffer_full_clr(hs[2]));
    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // a wait that used up its bound ends the run
    task automatic guard(input int n);
        if (n >= 40) begin
            bad_count++;
            $display("MISMATCH handshake expected done seen stuck");
            stop_test();
        end
    endtask
    // one register write, address and data offered together
    task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
        int n;
        logic aw_p, w_p;
        logic [1:0] r;
        aw_p = 1'h1;
        w_p = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= addr_w'({idx, 2'h0});
        s_axi_wdata <= {24'h0, val};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40 && (aw_p || w_p); n++) begin
            @(negedge aclk);
            if (s_axi_awready === 1'h1) aw_p = 1'h0;
            if (s_axi_wready === 1'h1) w_p = 1'h0;
            @(posedge aclk);
            if (!aw_p) s_axi_awvalid <= 1'h0;
            if (!w_p) s_axi_wvalid <= 1'h0;
        end
        guard(n);
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            r = s_axi_bresp;
            if (s_axi_bvalid === 1'h1) break;
        end
        guard(n);
        @(posedge aclk);
        s_axi_bready <= 1'h0;
        `CHK("bresp", er, r);
    endtask
    // one register read compared with the expected byte and response
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex, input logic [1:0] er);
        int n;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= addr_w'({idx, 2'h0});
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            if (s_axi_arready === 1'h1) break;
        end
        guard(n);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (s_axi_rvalid === 1'h1) break;
        end
        guard(n);
        @(posedge aclk);
        s_axi_rready <= 1'h0;
        `CHK("rdata", {24'h0, ex}, d);
        `CHK("rresp", er, r);
    endtask
    // let synchronisers and output registers catch up
    task automatic settle();
        repeat (5) @(posedge aclk);
        @(negedge aclk);
    endtask
    // one-cycle pulse on the slave hardware event inputs
    task automatic pulse(input logic [2:0] m);
        @(posedge aclk);
        hs <= m;
        @(posedge aclk);
        hs <= 3'h0;
        settle();
    endtask
    // hold reset for 16 cycles, then release
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
    endtask
    // reset values of directions and port-E register
    task automatic reset_regs();
        @(negedge aclk);
        `CHK("select", 1'h0, parallel_slave_select);
        rd_chk(third_port_direction_idx, 8'hFF, resp_okay);
        rd_chk(fourth_port_direction_idx, 8'hFF, resp_okay);
        rd_chk(fifth_port_direction_status_idx, 8'h07, resp_okay);
    endtask
    // main sequence
    initial begin
        do_reset();
        @(negedge aclk);
        `CHK("third oe", 8'h00, third_port_oe);
        `CHK("fourth oe", 8'h00, fourth_port_oe);
        reset_regs();
        rd_chk(irq_mask_idx, 8'h00, resp_okay);
        @(posedge aclk);
        third_port_in <= 8'h5A;
        wr(third_port_data_idx, 8'hAA, resp_okay);
        wr(third_port_direction_idx, 8'h0F, resp_okay);
        settle();
        `CHK("third oe", 8'hF0, third_port_oe);
        `CHK("third out", 8'hA0, third_port_out & third_port_oe);
        rd_chk(third_port_data_idx, 8'h5A, resp_okay);
        wr(override_out_idx, 8'h01, resp_okay);
        wr(override_in_idx, 8'h80, resp_okay);
        settle();
        `CHK("forced oe", 8'h71, third_port_oe);
        rd_chk(third_port_direction_idx, 8'h0F, resp_okay);
        wr(override_out_idx, 8'h00, resp_okay);
        wr(override_in_idx, 8'h00, resp_okay);
        wr(fourth_port_data_idx, 8'h55, resp_okay);
        wr(fourth_port_direction_idx, 8'h3C, resp_okay);
        @(posedge aclk);
        fourth_port_in <= 8'h96;
        settle();
        `CHK("fourth oe", 8'hC3, fourth_port_oe);
        `CHK("fourth out", 8'h41, fourth_port_out & fourth_port_oe);
        rd_chk(fourth_port_data_idx, 8'h96, resp_okay);
        // interrupt raised, masked and cleared
        wr(irq_status_idx, 8'h03, resp_okay);
        wr(irq_mask_idx, 8'h01, resp_okay);
        @(posedge aclk);
        third_port_in <= 8'hA5;
        settle();
        `CHK("irq", 1'h1, irq);
        rd_chk(irq_status_idx, 8'h01, resp_okay);
        wr(irq_status_idx, 8'h01, resp_okay);
        settle();
        `CHK("irq", 1'h0, irq);
        wr(irq_mask_idx, 8'h02, resp_okay);
        @(posedge aclk);
        third_port_in <= 8'h00;
        settle();
        `CHK("irq", 1'h0, irq);
        @(posedge aclk);
        fourth_port_in <= 8'h69;
        settle();
        `CHK("irq", 1'h1, irq);
        rd_chk(irq_status_idx, 8'h03, resp_okay);
        wr(irq_status_idx, 8'h03, resp_okay);
        rd_chk(8'h40, 8'h00, resp_slverr);
        wr(8'h40, 8'hFF, resp_slverr);
        // parallel slave mode and its status flags
        @(posedge aclk);
        fourth_port_in <= 8'h3C;
        wr(fifth_port_direction_status_idx, 8'h10, resp_okay);
        settle();
        `CHK("select", 1'h1, parallel_slave_select);
        rd_chk(fifth_port_direction_status_idx, 8'h10, resp_okay);
        @(posedge aclk);
        slave_data_in <= 8'hA5;
        slave_drive <= 1'h1;
        settle();
        `CHK("slave oe", 8'hFF, fourth_port_oe);
        `CHK("slave out", 8'hA5, fourth_port_out);
        `CHK("slave in", 8'h3C, slave_data_out);
        @(posedge aclk);
        slave_drive <= 1'h0;
        settle();
        `CHK("slave oe", 8'h00, fourth_port_oe);
        pulse(3'h1);
        rd_chk(fifth_port_direction_status_idx, 8'h90, resp_okay);
        pulse(3'h1);
        rd_chk(fifth_port_direction_status_idx, 8'hB0, resp_okay);
        rd_chk(fourth_port_data_idx, 8'h3C, resp_okay);
        rd_chk(fifth_port_direction_status_idx, 8'h30, resp_okay);
        wr(fifth_port_direction_status_idx, 8'h1F, resp_okay);
        rd_chk(fifth_port_direction_status_idx, 8'h17, resp_okay);
        pulse(3'h2);
        rd_chk(fifth_port_direction_status_idx, 8'h57, resp_okay);
        pulse(3'h4);
        rd_chk(fifth_port_direction_status_idx, 8'h17, resp_okay);
        // second reset in mid-run
        do_reset();
        reset_regs();
        stop_test();
    end
endmodule // tb_top
bind dual_bidirectional_port port_checker port_checker_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .fourth_port_oe(fourth_port_oe),
    .parallel_slave_select(parallel_slave_select));
